// *** pkg/cil_pkg.sv ***
// constants and types for the core interrupt logic
// assumes a single instruction clock and the register bus slave in hw/cil_core_irq.sv
package cil_pkg;

	// register indices; byte address is four times the index
	localparam logic [9:0] CIL_IDX_CTRL = 10'h00b;
	localparam logic [9:0] CIL_IDX_PFLAG = 10'h00c;
	localparam logic [9:0] CIL_IDX_PMASK = 10'h08c;

	// source counts: three core sources, seven peripheral sources
	localparam int CIL_NCORE = 3;
	localparam int CIL_NPERI = 7;

	// core source order inside irq_control_reg flag and enable fields
	localparam int CIL_SRC_PORTB = 0;
	localparam int CIL_SRC_EXT = 1;
	localparam int CIL_SRC_TIMER = 2;

	// irq_control_reg field positions
	localparam int CIL_GLB_EN_BIT = 7;
	localparam int CIL_GRP_EN_BIT = 6;
	localparam int CIL_CEN_LSB = 3;
	localparam int CIL_CFLAG_LSB = 0;

	// values after reset
	localparam logic [7:0] CIL_CTRL_RST = 8'h00;
	localparam logic [6:0] CIL_PFLAG_RST = 7'h00;
	localparam logic [6:0] CIL_PMASK_RST = 7'h00;
	localparam logic [31:0] CIL_PRDATA_RST = 32'h0000_0000;

	// interrupt vector address loaded into the program counter
	localparam logic [12:0] CIL_VECTOR_PC = 13'h0004;
	localparam logic [12:0] CIL_PC_RST = 13'h0000;

	// pipeline depth for external events: early phase three cycles, late phase four
	localparam int CIL_EXT_LAT_EARLY = 3;
	localparam int CIL_EXT_LAT_LATE = 4;

	typedef enum logic [2:0] {
		CIL_IDLE = 3'b001,
		CIL_VECTOR = 3'b010,
		CIL_SERVICE = 3'b100
	} cil_state_e;

endpackage

// *** pkg/cil_flag_if.sv ***
// carrier between the interrupt controller and its sticky flag banks
// assumes one clock; all signals are sampled on the bank's clock edge
`timescale 1ns/10ps
`default_nettype none
interface cil_flag_if #(
	parameter int W = 3
);
	logic [W-1:0] set;
	logic wr_en;
	logic [W-1:0] wr_data;
	logic [W-1:0] flags;

	modport bank (
		input set,
		input wr_en,
		input wr_data,
		output flags
	);

	modport ctrl (
		output set,
		output wr_en,
		output wr_data,
		input flags
	);
endinterface
`default_nettype wire

// *** hw/cil_flag_bank.sv ***
// sticky interrupt flag bank of parameterised width
// assumes set pulses and software writes arrive on the same clock
`timescale 1ns/10ps
`default_nettype none
module cil_flag_bank
	import cil_pkg::*;
#(
	parameter int W = 3
) (
	input wire logic clock,
	input wire logic srst,
	cil_flag_if.bank fif
);
	typedef struct packed {
		logic [W-1:0] flags;
	} cil_bank_s;

	cil_bank_s q;
	cil_bank_s d;

	always_comb begin
		d = q;
		if (fif.wr_en) begin
			d.flags = fif.wr_data;
		end
		// set regardless of masks
		// set after the write so an event beats a clear
		d.flags = d.flags | fif.set;
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			q.flags <= '0;
		end else begin
			q <= d;
		end
	end

	assign fif.flags = q.flags;
endmodule
`default_nettype wire

// *** hw/cil_core_irq.sv ***
// interrupt request logic of an 8-bit core, with an apb register slave
// assumes event inputs are one-cycle pulses synchronous to clock,
// and that the sequencer honours vector_take and return_from_isr_op
//
// Function
// - Up to ten sources, each with own flag and own enable bit.
// - A flag sets on its event whatever the masks or global enable.
// - global_irq_enable, control bit 7, allows unmasked interrupts or blocks all.
// - Global enable plus flag and mask, and group enable for peripherals, set vectors without further delay.
// - Every reset clears global_irq_enable.
// - return_from_isr_op leaves the routine and sets global_irq_enable.
// - Pin edge, port change, timer overflow flags and enables live in control.
// - Peripheral flags, masks in own registers; group enable in control.
// - Servicing clears global enable, pushes return address, loads pc 0004h.
// - External event to vector takes three or four cycles by phase.
// - Latency does not depend on one or two cycle instructions.
`timescale 1ns/10ps
`default_nettype none
module cil_core_irq
	import cil_pkg::*;
(
	input wire logic clock,
	input wire logic srst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// event sources
	input wire logic ext_irq_pin_edge,
	input wire logic ext_irq_pin_late,
	input wire logic port_b_change,
	input wire logic port_b_change_late,
	input wire logic first_timer_overflow,
	input wire logic [6:0] periph_event,
	// processor sequencer
	input wire logic return_from_isr_op,
	output logic vector_take,
	output logic push_return,
	output logic [12:0] pc_load,
	output logic in_service,
	output logic global_irq_enable
);
	typedef struct packed {
		cil_state_e state;
		logic glb_en;
		logic grp_en;
		logic [CIL_NCORE-1:0] core_en;
		logic [CIL_NPERI-1:0] pmask;
		logic [1:0] ext_s1;
		logic [1:0] ext_late;
		logic [1:0] ext_s2;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic vector_take;
		logic push_return;
		logic [12:0] pc_load;
		logic in_service;
	} cil_main_s;

	cil_main_s q;
	cil_main_s d;

	cil_flag_if #(.W(CIL_NCORE)) core_fif ();
	cil_flag_if #(.W(CIL_NPERI)) peri_fif ();

	cil_flag_bank #(
		.W(CIL_NCORE)
	) u_core_flags (
		.clock(clock),
		.srst(srst),
		.fif(core_fif.bank)
	);

	cil_flag_bank #(
		.W(CIL_NPERI)
	) u_peri_flags (
		.clock(clock),
		.srst(srst),
		.fif(peri_fif.bank)
	);

	logic [9:0] idx;
	logic setup_hit;
	logic acc_done;
	logic wr_ok;
	logic hit_ctrl;
	logic hit_pflag;
	logic hit_pmask;
	logic core_req;
	logic peri_req;
	logic take;
	logic [CIL_NCORE-1:0] core_set;

	assign idx = paddr[11:2];
	assign hit_ctrl = (idx == CIL_IDX_CTRL);
	assign hit_pflag = (idx == CIL_IDX_PFLAG);
	assign hit_pmask = (idx == CIL_IDX_PMASK);

	// one wait state: pready rises in the second access cycle
	assign setup_hit = psel & penable & ~q.pready;
	assign acc_done = psel & penable & q.pready;
	// only byte lane 0 carries register bits
	assign wr_ok = acc_done & pwrite & pstrb[0];

	// no instruction length input, so latency is fixed by phase alone
	assign core_set[CIL_SRC_PORTB] = q.ext_s1[0] | q.ext_s2[0];
	assign core_set[CIL_SRC_EXT] = q.ext_s1[1] | q.ext_s2[1];
	assign core_set[CIL_SRC_TIMER] = first_timer_overflow;

	assign core_fif.set = core_set;
	assign peri_fif.set = periph_event;

	assign core_fif.wr_en = wr_ok & hit_ctrl;
	assign core_fif.wr_data = pwdata[CIL_CFLAG_LSB +: CIL_NCORE];
	assign peri_fif.wr_en = wr_ok & hit_pflag;
	assign peri_fif.wr_data = pwdata[CIL_NPERI-1:0];

	// core source needs flag and enable
	assign core_req = |(core_fif.flags & q.core_en);
	// peripheral needs flag, mask, group enable
	assign peri_req = q.grp_en & (|(peri_fif.flags & q.pmask));
	// take as soon as request stands
	assign take = q.glb_en & (core_req | peri_req) & (q.state != CIL_VECTOR);

	always_comb begin
		d = q;
		d.vector_take = 1'b0;
		d.push_return = 1'b0;

		// external event phase pipeline
		d.ext_s1[0] = port_b_change & ~port_b_change_late;
		d.ext_late[0] = port_b_change & port_b_change_late;
		d.ext_s1[1] = ext_irq_pin_edge & ~ext_irq_pin_late;
		d.ext_late[1] = ext_irq_pin_edge & ext_irq_pin_late;
		// late arrivals wait one more cycle
		d.ext_s2 = q.ext_late;

		// apb answer, registered so outputs come from flops
		d.pready = setup_hit;
		d.pslverr = 1'b0;
		if (setup_hit) begin
			d.pslverr = ~(hit_ctrl | hit_pflag | hit_pmask);
			d.prdata = 32'h0000_0000;
			if (hit_ctrl) begin
				// flags and enables side by side
				d.prdata[CIL_GLB_EN_BIT] = q.glb_en;
				d.prdata[CIL_GRP_EN_BIT] = q.grp_en;
				d.prdata[CIL_CEN_LSB +: CIL_NCORE] = q.core_en;
				d.prdata[CIL_CFLAG_LSB +: CIL_NCORE] = core_fif.flags;
			end else if (hit_pflag) begin
				// unimplemented top bit reads zero
				d.prdata[CIL_NPERI-1:0] = peri_fif.flags;
			end else if (hit_pmask) begin
				d.prdata[CIL_NPERI-1:0] = q.pmask;
			end
		end

		// register writes
		if (wr_ok && hit_ctrl) begin
			// software sets or clears global enable
			d.glb_en = pwdata[CIL_GLB_EN_BIT];
			d.grp_en = pwdata[CIL_GRP_EN_BIT];
			d.core_en = pwdata[CIL_CEN_LSB +: CIL_NCORE];
		end
		if (wr_ok && hit_pmask) begin
			d.pmask = pwdata[CIL_NPERI-1:0];
		end

		// sequencer handshake
		case (q.state)
			CIL_IDLE: begin
				d.in_service = 1'b0;
			end
			CIL_VECTOR: begin
				d.state = CIL_SERVICE;
				d.in_service = 1'b1;
			end
			CIL_SERVICE: begin
				d.in_service = 1'b1;
			end
			default: begin
				d.state = CIL_IDLE;
				d.in_service = 1'b0;
			end
		endcase

		if (return_from_isr_op) begin
			d.glb_en = 1'b1;
			d.state = CIL_IDLE;
			d.in_service = 1'b0;
		end

		if (take) begin
			// clear enable, push, vector
			// hardware clear overrides a same-cycle software write
			d.glb_en = 1'b0;
			d.push_return = 1'b1;
			d.vector_take = 1'b1;
			d.pc_load = CIL_VECTOR_PC;
			d.state = CIL_VECTOR;
			d.in_service = 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			q.state <= CIL_IDLE;
			q.glb_en <= CIL_CTRL_RST[CIL_GLB_EN_BIT];
			q.grp_en <= CIL_CTRL_RST[CIL_GRP_EN_BIT];
			q.core_en <= CIL_CTRL_RST[CIL_CEN_LSB +: CIL_NCORE];
			q.pmask <= CIL_PMASK_RST;
			q.ext_s1 <= 2'h0;
			q.ext_late <= 2'h0;
			q.ext_s2 <= 2'h0;
			q.prdata <= CIL_PRDATA_RST;
			q.pready <= 1'b0;
			q.pslverr <= 1'b0;
			q.vector_take <= 1'b0;
			q.push_return <= 1'b0;
			q.pc_load <= CIL_PC_RST;
			q.in_service <= 1'b0;
		end else begin
			q <= d;
		end
	end

	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign vector_take = q.vector_take;
	assign push_return = q.push_return;
	assign pc_load = q.pc_load;
	assign in_service = q.in_service;
	assign global_irq_enable = q.glb_en;
endmodule
`default_nettype wire

// *** testbench/cil_irq_sva.sv ***
// port checker for the core interrupt logic
// assumes one clock and synchronous active-high srst
`timescale 1ns/10ps
`default_nettype none
module cil_irq_sva
	import cil_pkg::*;
(
	input wire logic clock,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31:0] prdata,
	input wire logic return_from_isr_op,
	input wire logic vector_take,
	input wire logic push_return,
	input wire logic [12:0] pc_load,
	input wire logic in_service,
	input wire logic global_irq_enable
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (srst);
	sequence s_wait;
		psel && penable && !pready;
	endsequence
	sequence s_take;
		vector_take && push_return;
	endsequence
	ready_wait_a: assert property (s_wait |=> pready) else $error("ready late");
	ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
	err_ready_a: assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad error");
	take_vector_a: assert property (vector_take |-> s_take ##0 pc_load == CIL_VECTOR_PC)
		else $error("bad vector entry");
	take_pulse_a: assert property (s_take |=> !vector_take && in_service)
		else $error("take not a pulse");
	take_enable_a: assert property (vector_take |-> $past(global_irq_enable) && !global_irq_enable)
		else $error("take without enable");
	return_enable_a: assert property (return_from_isr_op |=> global_irq_enable && !in_service)
		else $error("return left enable low");
	reset_clear_a: assert property ($fell(srst) |-> !global_irq_enable && !in_service)
		else $error("enable after reset");
endmodule
bind cil_core_irq cil_irq_sva i_cil_irq_sva (.clock(clock), .srst(srst), .psel(psel),
	.penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata),
	.return_from_isr_op(return_from_isr_op), .vector_take(vector_take),
	.push_return(push_return), .pc_load(pc_load), .in_service(in_service),
	.global_irq_enable(global_irq_enable));
`default_nettype wire

// *** testbench/cil_seq_model.sv ***
// sequencer model: leaves the routine when software asks
// assumes requests come from the bench software
`timescale 1ns/10ps
`default_nettype none
module cil_seq_model (
	input wire logic clock,
	input wire logic ret_req,
	input wire logic in_service,
	output var logic return_from_isr_op
);
	initial return_from_isr_op = 1'b0;
	always @(posedge clock) begin
		return_from_isr_op <= ret_req && in_service;
	end
endmodule
`default_nettype wire

// *** testbench/tb_core_interrupt_logic.sv ***
// bench for the core interrupt logic: apb software and events
// assumes the sequencer model answers return requests
`timescale 1ns/10ps
`default_nettype none
module tb_core_interrupt_logic
	import cil_pkg::*;
;
	localparam logic [11:0] a_ctrl = {CIL_IDX_CTRL, 2'b00};
	localparam logic [11:0] a_pflg = {CIL_IDX_PFLAG, 2'b00};
	localparam logic [11:0] a_pmsk = {CIL_IDX_PMASK, 2'b00};
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ret_req = 1'b0, er;
	logic [11:0] paddr = '0, ev = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic pready, pslverr, vector_take, push_return, in_service, global_irq_enable;
	logic return_from_isr_op;
	logic [12:0] pc_load;
	int errors = 0, samples_checked = 0;
	always #50 clock = ~clock;
	cil_core_irq i_cil_core_irq (.clock(clock), .srst(srst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ext_irq_pin_edge(ev[0]), .ext_irq_pin_late(ev[1]), .port_b_change(ev[2]),
		.port_b_change_late(ev[3]), .first_timer_overflow(ev[4]),
		.periph_event(ev[11:5]), .return_from_isr_op(return_from_isr_op),
		.vector_take(vector_take), .push_return(push_return), .pc_load(pc_load),
		.in_service(in_service), .global_irq_enable(global_irq_enable));
	cil_seq_model i_cil_seq_model (.clock(clock), .ret_req(ret_req),
		.in_service(in_service), .return_from_isr_op(return_from_isr_op));
	task tally_and_finish();
		$display("checked %0d wrong %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] x);
		samples_checked++;
		if (s !== x) begin
			errors++;
			$display("wrong value at %0t: %h expected %h", $time, s, x);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge clock) psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock) penable <= 1'b1;
		// look mid-cycle where pready has settled, release on the next edge
		for (i = 0; i < 20; i++) begin
			@(negedge clock);
			if (pready === 1'b1) break;
		end
		rd = prdata;
		er = pslverr;
		@(posedge clock);
		psel <= 1'b0;
		penable <= 1'b0;
		if (i == 20) begin
			errors++;
			tally_and_finish();
		end
	endtask
	// one event with its setup; lat 0 means no vector expected
	task fire(input logic [11:0] e, input logic [7:0] c, input logic [6:0] m,
		input int lat, input logic [11:0] fa, input logic [7:0] fx);
		int n;
		n = 0;
		apb(1'b1, a_pmsk, {25'h0, m});
		apb(1'b1, a_ctrl, {24'h0, c});
		@(posedge clock) ev <= e;
		for (int i = 1; i < 9; i++) begin
			@(posedge clock) ev <= '0;
			#1;
			if (vector_take === 1'b1) begin
				n = i;
				chk(pc_load, CIL_VECTOR_PC);
				chk(push_return, 1'b1);
			end
		end
		chk(n, lat);
		apb(1'b0, fa, 32'h0);
		chk(rd, {24'h0, fx});
		apb(1'b1, a_ctrl, {24'h0, c & 8'h78});
		apb(1'b1, a_pflg, 32'h0);
		if (lat > 0) begin
			@(posedge clock) ret_req <= 1'b1;
			@(posedge clock) ret_req <= 1'b0;
			@(posedge clock);
			#1 chk(global_irq_enable, 1'b1);
			chk(in_service, 1'b0);
		end
	endtask
	task t_reset();
		chk(global_irq_enable, 1'b0);
		apb(1'b0, a_ctrl, 32'h0);
		chk(rd, {24'h0, CIL_CTRL_RST});
		apb(1'b0, a_pflg, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, a_pmsk, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, 32'h0);
		chk(er, 1'b1);
		$display("reset test done");
	endtask
	task t_core();
		fire(12'h010, 8'ha0, 7'h00, 2, a_ctrl, 8'h24);
		fire(12'h001, 8'h90, 7'h00, 3, a_ctrl, 8'h12);
		fire(12'h003, 8'h90, 7'h00, 4, a_ctrl, 8'h12);
		fire(12'h004, 8'h88, 7'h00, 3, a_ctrl, 8'h09);
		fire(12'h00c, 8'h88, 7'h00, 4, a_ctrl, 8'h09);
		$display("core source test done");
	endtask
	task t_periph();
		fire(12'h100, 8'hc0, 7'h08, 2, a_pflg, 8'h08);
		fire(12'h100, 8'h80, 7'h08, 0, a_pflg, 8'h08);
		$display("peripheral test done");
	endtask
	task t_blocked();
		fire(12'h010, 8'h20, 7'h00, 0, a_ctrl, 8'h24);
		fire(12'h010, 8'h80, 7'h00, 0, a_ctrl, 8'h84);
		$display("blocked test done");
	endtask
	task t_rereset();
		apb(1'b1, a_ctrl, 32'h80);
		@(posedge clock) srst <= 1'b1;
		@(posedge clock);
		@(posedge clock) srst <= 1'b0;
		#1 chk(global_irq_enable, 1'b0);
		$display("second reset test done");
	endtask
	initial begin
		repeat (5) @(posedge clock);
		srst <= 1'b0;
		t_reset();
		t_core();
		t_periph();
		t_blocked();
		t_rereset();
		tally_and_finish();
	end
endmodule
`default_nettype wire
